// >>> src/timer8_cfg.svh
/*
 * Register offsets, field positions, reset values and codes of the 8-bit timer.
 * Assumes inclusion by bare name from the timer design files.
 */
`ifndef TIMER8_CFG_SVH
`define TIMER8_CFG_SVH

`define T8_ADDR_W            6
`define T8_OFS_COMPARE_A     6'h18
`define T8_OFS_CLOCK_CTRL    6'h1A
`define T8_OFS_OUT_CTRL      6'h1B
`define T8_OFS_IRQ_MASK      6'h3A
`define T8_OFS_COUNT         6'h1C
`define T8_OFS_COMPARE_B     6'h1D
`define T8_OFS_IRQ_FLAGS     6'h39
`define T8_OFS_VECTOR_ACK    6'h1E

`define T8_RESET_BYTE        8'h00
`define T8_ZERO_BYTE         8'h00
`define T8_MAX_VAL           8'hFF
`define T8_BOTTOM_VAL        8'h00
`define T8_ONE_BYTE          8'h01

`define T8_BIT_FORCE_A       7
`define T8_BIT_FORCE_B       6
`define T8_BIT_WAVE_HIGH     3
`define T8_BIT_OMODE_A_HI    7
`define T8_BIT_OMODE_A_LO    6
`define T8_BIT_OMODE_B_HI    5
`define T8_BIT_OMODE_B_LO    4
`define T8_BIT_CS_HI         2
`define T8_BIT_WM_HI         1
`define T8_BIT_MATCH_B       2
`define T8_BIT_OVF           1
`define T8_BIT_MATCH_A       0

`define T8_CS_STOP           3'h0
`define T8_CS_DIV1           3'h1
`define T8_CS_DIV8           3'h2
`define T8_CS_DIV64          3'h3
`define T8_CS_DIV256         3'h4
`define T8_CS_DIV1024        3'h5
`define T8_CS_EXT_FALL       3'h6
`define T8_CS_EXT_RISE       3'h7

`define T8_PS_W              10
`define T8_PS_TAP8           2
`define T8_PS_TAP64          5
`define T8_PS_TAP256         7
`define T8_PS_TAP1024        9
`define T8_PS_ONE            10'h001
`define T8_PS_ALL            10'h3FF

`define T8_OMODE_OFF         2'h0
`define T8_OMODE_TOGGLE      2'h1
`define T8_OMODE_CLEAR       2'h2
`define T8_OMODE_SET         2'h3

`endif

// >>> src/timer8_pkg.sv
/*
 * Types shared by the 8-bit timer design files.
 * Assumes the configuration header is compiled alongside.
 */
package timer8_pkg;
	typedef enum logic [2:0] {
		mode_normal, mode_phase_ff, mode_clear_on_match, mode_fast_ff,
		mode_res4, mode_phase_ocra, mode_res6, mode_fast_ocra
	} wave_mode_t;
endpackage : timer8_pkg

// >>> src/timer8_tick_gen.sv
/*
 * Timer tick enable: prescaler taps and synchronised external count pin.
 * Assumes the count pin is asynchronous to core_clk_in.
 */
`timescale 1ns/1ps
`default_nettype none
`include "timer8_cfg.svh"

module timer8_tick_gen #(
	parameter int PS_W = `T8_PS_W
) (
	input  wire logic       core_clk_in,
	input  wire logic       rst_in,
	input  wire logic [2:0] clock_select_in,
	input  wire logic       ext_count_pin_in,
	output logic            tick_out
);
	initial begin
		if (PS_W != `T8_PS_W) $error("prescaler width must be 10");
	end

	typedef struct packed {
		logic [PS_W-1:0] div;
		logic            sync1;
		logic            sync2;
		logic            pin_prev;
		logic            tick;
	} tick_state_t;

	tick_state_t state;
	tick_state_t next_state;
	logic        ps_hit;

	always_comb begin
		next_state = state;
		next_state.div = state.div + `T8_PS_ONE;
		next_state.sync1 = ext_count_pin_in;
		next_state.sync2 = state.sync1;
		next_state.pin_prev = state.sync2;
		ps_hit = 1'b0;
		// a tap fires when all lower bits are ones: one tick per 2^n cycles
		case (clock_select_in)
			`T8_CS_DIV8:    ps_hit = &state.div[`T8_PS_TAP8:0];
			`T8_CS_DIV64:   ps_hit = &state.div[`T8_PS_TAP64:0];
			`T8_CS_DIV256:  ps_hit = &state.div[`T8_PS_TAP256:0];
			`T8_CS_DIV1024: ps_hit = &state.div[`T8_PS_TAP1024:0];
			default:        ps_hit = 1'b0;
		endcase
		case (clock_select_in)
			`T8_CS_STOP:     next_state.tick = 1'b0;
			`T8_CS_DIV1:     next_state.tick = 1'b1;
			`T8_CS_EXT_FALL: next_state.tick = state.pin_prev & ~state.sync2;
			`T8_CS_EXT_RISE: next_state.tick = ~state.pin_prev & state.sync2;
			default:         next_state.tick = ps_hit;
		endcase
	end

	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign tick_out = state.tick;
endmodule : timer8_tick_gen
`default_nettype wire

// >>> src/timer8_mode_clock_compare.sv
/*
 * 8-bit timer/counter: mode decode, compare units, flags, Avalon-MM slave.
 * Assumes a same-clock Avalon-MM master and an asynchronous count pin.
 */
`timescale 1ns/1ps
`default_nettype none
`include "timer8_cfg.svh"

module timer8_mode_clock_compare #(
	parameter int ADDR_W = `T8_ADDR_W
) (
	input  wire logic              core_clk_in,
	input  wire logic              rst_in,
	input  wire logic [ADDR_W-1:0] avs_address_in,
	input  wire logic              avs_read_in,
	input  wire logic              avs_write_in,
	input  wire logic [7:0]        avs_writedata_in,
	output logic      [7:0]        avs_readdata_out,
	output logic                   avs_waitrequest_out,
	input  wire logic              global_irq_en_in,
	input  wire logic              ext_count_pin_in,
	output logic                   wave_out_a_out,
	output logic                   wave_out_b_out,
	output logic                   wave_out_a_en_out,
	output logic                   wave_out_b_en_out,
	output logic                   irq_match_a_out,
	output logic                   irq_match_b_out,
	output logic                   irq_overflow_out
);
	initial begin
		if (ADDR_W != `T8_ADDR_W) $error("address width must be 6");
	end

	typedef struct packed {
		logic [1:0] out_mode_a;
		logic [1:0] out_mode_b;
		logic [1:0] wave_mode_low;
		logic       wave_mode_high;
		logic [2:0] clock_select;
		logic [7:0] count_value;
		logic [7:0] compare_value_a;
		logic [7:0] compare_value_b;
		logic [7:0] buf_a;
		logic [7:0] buf_b;
		logic       count_down;
		logic       block_match;
		logic       match_a_irq_en;
		logic       match_b_irq_en;
		logic       overflow_irq_en;
		logic       match_a_flag;
		logic       match_b_flag;
		logic       overflow_flag;
		logic       wave_a;
		logic       wave_b;
		logic       wave_a_en;
		logic       wave_b_en;
		logic       irq_a;
		logic       irq_b;
		logic       irq_ovf;
		logic       ack;
		logic [7:0] rdata;
	} timer_state_t;

	timer_state_t          state;
	timer_state_t          next_state;
	timer8_pkg::wave_mode_t mode;
	logic                  tick;
	logic                  is_pwm;
	logic                  is_phase;
	logic                  is_fast;
	logic [7:0]            top;
	logic                  at_top;
	logic                  at_bottom;
	logic                  hit_a;
	logic                  hit_b;
	logic                  set_ovf;
	logic                  wr;
	logic                  rd;
	logic                  force_a;
	logic                  force_b;
	logic                  flag_write;
	logic                  ack_a;
	logic                  ack_b;
	logic                  ack_ovf;

	timer8_tick_gen #(
		.PS_W(`T8_PS_W)
	) u_tick (
		.core_clk_in      (core_clk_in),
		.rst_in           (rst_in),
		.clock_select_in  (state.clock_select),
		.ext_count_pin_in (ext_count_pin_in),
		.tick_out         (tick)
	);

	// out-of-range waveform codes behave as normal mode
	function automatic logic apply_match(input logic cur, input logic [1:0] om);
		case (om)
			`T8_OMODE_TOGGLE: apply_match = ~cur;
			`T8_OMODE_CLEAR:  apply_match = 1'b0;
			`T8_OMODE_SET:    apply_match = 1'b1;
			default:          apply_match = cur;
		endcase
	endfunction : apply_match

	always_comb begin
		next_state = state;
		mode = timer8_pkg::wave_mode_t'({state.wave_mode_high, state.wave_mode_low});
		is_phase = (mode == timer8_pkg::mode_phase_ff) || (mode == timer8_pkg::mode_phase_ocra);
		is_fast = (mode == timer8_pkg::mode_fast_ff) || (mode == timer8_pkg::mode_fast_ocra);
		is_pwm = is_phase || is_fast;
		case (mode)
			timer8_pkg::mode_clear_on_match,
			timer8_pkg::mode_phase_ocra,
			timer8_pkg::mode_fast_ocra: top = state.compare_value_a;
			default:                    top = `T8_MAX_VAL;
		endcase
		at_top = (state.count_value == top);
		at_bottom = (state.count_value == `T8_BOTTOM_VAL);
		wr = avs_write_in && !state.ack;
		rd = avs_read_in && !state.ack;
		flag_write = wr && (avs_address_in == `T8_OFS_IRQ_FLAGS);
		ack_a = wr && (avs_address_in == `T8_OFS_VECTOR_ACK) && avs_writedata_in[`T8_BIT_MATCH_A];
		ack_b = wr && (avs_address_in == `T8_OFS_VECTOR_ACK) && avs_writedata_in[`T8_BIT_MATCH_B];
		ack_ovf = wr && (avs_address_in == `T8_OFS_VECTOR_ACK) && avs_writedata_in[`T8_BIT_OVF];
		force_a = wr && (avs_address_in == `T8_OFS_CLOCK_CTRL) && !is_pwm
			&& avs_writedata_in[`T8_BIT_FORCE_A];
		force_b = wr && (avs_address_in == `T8_OFS_CLOCK_CTRL) && !is_pwm
			&& avs_writedata_in[`T8_BIT_FORCE_B];
		// continuous compare, gated on the tick and the post-write block
		hit_a = tick && !state.block_match && (state.count_value == state.compare_value_a);
		hit_b = tick && !state.block_match && (state.count_value == state.compare_value_b);
		set_ovf = 1'b0;
		if (tick) begin
			next_state.block_match = 1'b0;
			if (is_phase) begin
				if (state.count_down) begin
					next_state.count_value = state.count_value - `T8_ONE_BYTE;
					if (state.count_value == `T8_ONE_BYTE || at_bottom) begin
						next_state.count_down = 1'b0;
					end
				end else if (at_top) begin
					next_state.count_value = state.count_value - `T8_ONE_BYTE;
					next_state.count_down = 1'b1;
				end else begin
					next_state.count_value = state.count_value + `T8_ONE_BYTE;
				end
				if (at_bottom) set_ovf = 1'b1;
				if (at_top) begin
					next_state.compare_value_a = state.buf_a;
					next_state.compare_value_b = state.buf_b;
				end
			end else begin
				next_state.count_down = 1'b0;
				if (at_top) next_state.count_value = `T8_BOTTOM_VAL;
				else next_state.count_value = state.count_value + `T8_ONE_BYTE;
				if (mode == timer8_pkg::mode_fast_ocra) set_ovf = at_top;
				else set_ovf = (state.count_value == `T8_MAX_VAL);
				if (is_fast && at_top) begin
					next_state.compare_value_a = state.buf_a;
					next_state.compare_value_b = state.buf_b;
				end
			end
			if (hit_a) begin
				if (is_pwm) begin
					if (state.out_mode_a[1]) next_state.wave_a = state.out_mode_a[0] ^ state.count_down;
					else if (state.out_mode_a[0] && state.wave_mode_high) next_state.wave_a = ~state.wave_a;
				end else begin
					next_state.wave_a = apply_match(state.wave_a, state.out_mode_a);
				end
			end
			if (hit_b) begin
				if (is_pwm) begin
					if (state.out_mode_b[1]) next_state.wave_b = state.out_mode_b[0] ^ state.count_down;
				end else begin
					next_state.wave_b = apply_match(state.wave_b, state.out_mode_b);
				end
			end
			if (is_fast && at_top) begin
				if (state.out_mode_a[1]) next_state.wave_a = ~state.out_mode_a[0];
				if (state.out_mode_b[1]) next_state.wave_b = ~state.out_mode_b[0];
			end
		end
		if (force_a) next_state.wave_a = apply_match(state.wave_a, state.out_mode_a);
		if (force_b) next_state.wave_b = apply_match(state.wave_b, state.out_mode_b);
		// set beats clear so a match in the clearing cycle survives
		if ((flag_write && avs_writedata_in[`T8_BIT_MATCH_A]) || ack_a) next_state.match_a_flag = 1'b0;
		if ((flag_write && avs_writedata_in[`T8_BIT_MATCH_B]) || ack_b) next_state.match_b_flag = 1'b0;
		if ((flag_write && avs_writedata_in[`T8_BIT_OVF]) || ack_ovf) next_state.overflow_flag = 1'b0;
		if (hit_a) next_state.match_a_flag = 1'b1;
		if (hit_b) next_state.match_b_flag = 1'b1;
		if (set_ovf) next_state.overflow_flag = 1'b1;
		if (wr) begin
			case (avs_address_in)
				`T8_OFS_OUT_CTRL: begin
					next_state.out_mode_a = avs_writedata_in[`T8_BIT_OMODE_A_HI:`T8_BIT_OMODE_A_LO];
					next_state.out_mode_b = avs_writedata_in[`T8_BIT_OMODE_B_HI:`T8_BIT_OMODE_B_LO];
					next_state.wave_mode_low = avs_writedata_in[`T8_BIT_WM_HI:0];
				end
				`T8_OFS_CLOCK_CTRL: begin
					next_state.wave_mode_high = avs_writedata_in[`T8_BIT_WAVE_HIGH];
					next_state.clock_select = avs_writedata_in[`T8_BIT_CS_HI:0];
				end
				`T8_OFS_COUNT: begin
					next_state.count_value = avs_writedata_in;
					next_state.block_match = 1'b1;
				end
				`T8_OFS_COMPARE_A: begin
					next_state.buf_a = avs_writedata_in;
					if (!is_pwm) next_state.compare_value_a = avs_writedata_in;
				end
				`T8_OFS_COMPARE_B: begin
					next_state.buf_b = avs_writedata_in;
					if (!is_pwm) next_state.compare_value_b = avs_writedata_in;
				end
				`T8_OFS_IRQ_MASK: begin
					next_state.match_a_irq_en = avs_writedata_in[`T8_BIT_MATCH_A];
					next_state.match_b_irq_en = avs_writedata_in[`T8_BIT_MATCH_B];
					next_state.overflow_irq_en = avs_writedata_in[`T8_BIT_OVF];
				end
				default: begin
				end
			endcase
		end
		next_state.rdata = `T8_ZERO_BYTE;
		if (rd) begin
			case (avs_address_in)
				`T8_OFS_OUT_CTRL:   next_state.rdata = {state.out_mode_a, state.out_mode_b,
					2'h0, state.wave_mode_low};
				`T8_OFS_CLOCK_CTRL: next_state.rdata = {2'h0, 2'h0,
					state.wave_mode_high, state.clock_select};
				`T8_OFS_COUNT:      next_state.rdata = state.count_value;
				`T8_OFS_COMPARE_A:  next_state.rdata = is_pwm ? state.buf_a : state.compare_value_a;
				`T8_OFS_COMPARE_B:  next_state.rdata = is_pwm ? state.buf_b : state.compare_value_b;
				`T8_OFS_IRQ_MASK:   next_state.rdata = {5'h00, state.match_b_irq_en,
					state.overflow_irq_en, state.match_a_irq_en};
				`T8_OFS_IRQ_FLAGS:  next_state.rdata = {5'h00, state.match_b_flag,
					state.overflow_flag, state.match_a_flag};
				default:            next_state.rdata = `T8_ZERO_BYTE;
			endcase
		end
		// one wait cycle per access keeps read data registered
		next_state.ack = (avs_read_in || avs_write_in) && !state.ack;
		next_state.wave_a_en = (state.out_mode_a != `T8_OMODE_OFF);
		next_state.wave_b_en = (state.out_mode_b != `T8_OMODE_OFF);
		next_state.irq_a = state.match_a_irq_en && global_irq_en_in && state.match_a_flag;
		next_state.irq_b = state.match_b_irq_en && global_irq_en_in && state.match_b_flag;
		next_state.irq_ovf = state.overflow_irq_en && global_irq_en_in && state.overflow_flag;
	end

	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign avs_readdata_out = state.rdata;
	assign avs_waitrequest_out = !state.ack;
	assign wave_out_a_out = state.wave_a;
	assign wave_out_b_out = state.wave_b;
	assign wave_out_a_en_out = state.wave_a_en;
	assign wave_out_b_en_out = state.wave_b_en;
	assign irq_match_a_out = state.irq_a;
	assign irq_match_b_out = state.irq_b;
	assign irq_overflow_out = state.irq_ovf;
endmodule : timer8_mode_clock_compare
`default_nettype wire

// >>> verification/timer8_mode_clock_compare_sva.sv
/*
 * Port-level checker for the 8-bit timer: bus handshake, reserved bits, irq gating.
 * Assumes it is bound into the timer top module and sees only its ports.
 */
`timescale 1ns/1ps
`default_nettype none
`include "timer8_cfg.svh"

module timer8_mode_clock_compare_sva #(
	parameter int ADDR_W = `T8_ADDR_W
) (
	input wire logic              core_clk_in,
	input wire logic              rst_in,
	input wire logic [ADDR_W-1:0] avs_address_in,
	input wire logic              avs_read_in,
	input wire logic              avs_write_in,
	input wire logic [7:0]        avs_writedata_in,
	input wire logic [7:0]        avs_readdata_out,
	input wire logic              avs_waitrequest_out,
	input wire logic              global_irq_en_in,
	input wire logic              ext_count_pin_in,
	input wire logic              wave_out_a_out,
	input wire logic              wave_out_b_out,
	input wire logic              wave_out_a_en_out,
	input wire logic              wave_out_b_en_out,
	input wire logic              irq_match_a_out,
	input wire logic              irq_match_b_out,
	input wire logic              irq_overflow_out
);
	default clocking cb @(posedge core_clk_in);
	endclocking
	default disable iff (rst_in);

	AST_ANSWER_NEXT: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out
		|=> !avs_waitrequest_out) else $error("bus answer not one cycle after request");
	AST_ANSWER_ONE: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
		else $error("waitrequest low for more than one cycle");
	AST_IDLE_ZERO: assert property (avs_waitrequest_out |-> avs_readdata_out == 8'h00)
		else $error("read data not zero outside answer cycle");
	AST_RES_OUT_CTRL: assert property (!avs_waitrequest_out
		&& $past(avs_read_in && avs_address_in == `T8_OFS_OUT_CTRL)
		|-> avs_readdata_out[3:2] == 2'h0) else $error("reserved out control bits read one");
	AST_RES_CLOCK_CTRL: assert property (!avs_waitrequest_out
		&& $past(avs_read_in && avs_address_in == `T8_OFS_CLOCK_CTRL)
		|-> avs_readdata_out[7:4] == 4'h0) else $error("force or reserved bits read one");
	AST_IRQ_A_GATED: assert property (!$past(global_irq_en_in) |-> !irq_match_a_out)
		else $error("compare a irq without global enable");
	AST_IRQ_B_GATED: assert property ($fell(global_irq_en_in) |=> !irq_match_b_out)
		else $error("compare b irq after global enable fell");
	AST_IRQ_OVF_GATED: assert property (!global_irq_en_in [*2] |-> !irq_overflow_out)
		else $error("overflow irq without global enable");
	AST_EN_BY_WRITE: assert property ($changed(wave_out_a_en_out) |-> $past(avs_write_in))
		else $error("output enable changed without a register write");

	COV_WRITE: cover property (avs_write_in && !avs_waitrequest_out);
	COV_OVF_IRQ: cover property (irq_overflow_out);
	COV_WAVE_A: cover property ($changed(wave_out_a_out));
endmodule : timer8_mode_clock_compare_sva

bind timer8_mode_clock_compare timer8_mode_clock_compare_sva #(.ADDR_W(ADDR_W)) sva (
	.core_clk_in(core_clk_in), .rst_in(rst_in), .avs_address_in(avs_address_in),
	.avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
	.avs_writedata_in(avs_writedata_in), .avs_readdata_out(avs_readdata_out),
	.avs_waitrequest_out(avs_waitrequest_out), .global_irq_en_in(global_irq_en_in),
	.ext_count_pin_in(ext_count_pin_in), .wave_out_a_out(wave_out_a_out),
	.wave_out_b_out(wave_out_b_out), .wave_out_a_en_out(wave_out_a_en_out),
	.wave_out_b_en_out(wave_out_b_en_out), .irq_match_a_out(irq_match_a_out),
	.irq_match_b_out(irq_match_b_out), .irq_overflow_out(irq_overflow_out));

`default_nettype wire

// >>> verification/tb_top.sv
/*
 * Self-checking testbench for the 8-bit timer through its register bus.
 * Assumes the timer top module and its configuration header are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
`include "timer8_cfg.svh"

module tb_top;
	logic       core_clk_in = 1'b0;
	logic       rst_in = 1'b1;
	logic [5:0] avs_address_in = 6'h00;
	logic       avs_read_in = 1'b0;
	logic       avs_write_in = 1'b0;
	logic [7:0] avs_writedata_in = 8'h00;
	logic       global_irq_en_in = 1'b0;
	logic       ext_count_pin_in = 1'b0;
	logic [7:0] avs_readdata_out;
	logic       avs_waitrequest_out;
	logic       wave_a, wave_b, en_a, en_b, irq_a, irq_b, irq_ovf;
	logic [7:0] q;
	int         n_mismatch = 0;
	int         checked = 0;
	int         div[5] = '{1, 8, 64, 256, 1024};
	int         num[5] = '{200, 100, 100, 40, 10};
	int         win[7] = '{150, 150, 150, 150, 150, 150, 20};
	logic [2:0] md[7] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h5, 3'h7, 3'h0};
	logic [7:0] st[7] = '{8'hF0, 8'hF0, 8'h30, 8'hF0, 8'h30, 8'h30, 8'h40};
	logic [7:0] fl[7] = '{8'h03, 8'h04, 8'h01, 8'h03, 8'h03, 8'h03, 8'h00};
	logic [1:0] om[4] = '{2'h3, 2'h2, 2'h1, 2'h1};
	logic       wv[4] = '{1'b1, 1'b0, 1'b1, 1'b0};

	always #5 core_clk_in = ~core_clk_in;

	timer8_mode_clock_compare dut (.core_clk_in(core_clk_in), .rst_in(rst_in),
		.avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
		.avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
		.avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
		.global_irq_en_in(global_irq_en_in), .ext_count_pin_in(ext_count_pin_in),
		.wave_out_a_out(wave_a), .wave_out_b_out(wave_b), .wave_out_a_en_out(en_a),
		.wave_out_b_en_out(en_b), .irq_match_a_out(irq_a), .irq_match_b_out(irq_b),
		.irq_overflow_out(irq_ovf));

	task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
		checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	// an idle cycle before each request keeps a driver from assigning twice in one step
	task automatic acc(input logic w, input logic [5:0] a, input logic [7:0] d,
		output logic [7:0] r);
		int   n;
		logic seen;
		@(posedge core_clk_in);
		avs_address_in <= a;
		avs_writedata_in <= d;
		avs_read_in <= ~w;
		avs_write_in <= w;
		n = 0;
		// answer is looked at mid-cycle, where it stands settled before the sampling edge
		do begin
			@(negedge core_clk_in);
			seen = avs_waitrequest_out;
			r = avs_readdata_out;
			@(posedge core_clk_in);
			n++;
		end while (seen !== 1'b0 && n < 40);
		avs_read_in <= 1'b0;
		avs_write_in <= 1'b0;
		if (n >= 40) chk("waitrequest", 8'h00, 8'h01);
	endtask : acc

	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		logic [7:0] r;
		acc(1'b1, a, d, r);
	endtask : wr

	task automatic rdc(input logic [5:0] a, input logic [7:0] e, input string name);
		logic [7:0] r;
		acc(1'b0, a, 8'h00, r);
		chk(name, e, r);
	endtask : rdc

	task automatic ctl(input logic [7:0] d);
		wr(`T8_OFS_CLOCK_CTRL, d);
	endtask : ctl

	task automatic test_done;
		$display("comparisons %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : test_done

	initial begin
		repeat (100000) @(posedge core_clk_in);
		n_mismatch++;
		test_done();
	end

	initial begin
		repeat (4) @(posedge core_clk_in);
		rst_in <= 1'b0;
		rdc(`T8_OFS_COMPARE_A, 8'h00, "compare_a");
		rdc(`T8_OFS_IRQ_MASK, 8'h00, "irq_mask");
		wr(`T8_OFS_OUT_CTRL, 8'hFF);
		rdc(`T8_OFS_OUT_CTRL, 8'hF3, "out_ctrl");
		wr(`T8_OFS_OUT_CTRL, 8'h00);
		ctl(8'hC0);
		rdc(`T8_OFS_CLOCK_CTRL, 8'h00, "force read");
		ctl(8'h3F);
		rdc(`T8_OFS_CLOCK_CTRL, 8'h0F, "clock_ctrl");
		ctl(8'h00);
		wr(6'h00, 8'h5A);
		rdc(6'h00, 8'h00, "unmapped");
		$display("test registers done");
		// prescaler phase is unknown, so a count may land a couple of ticks off
		for (int i = 0; i < 5; i++) begin
			wr(`T8_OFS_COUNT, 8'h00);
			ctl({5'h00, 3'(i + 1)});
			// the start and stop accesses add three clock cycles of their own
			repeat (div[i] * num[i] - 3) @(posedge core_clk_in);
			ctl(8'h00);
			acc(1'b0, `T8_OFS_COUNT, 8'h00, q);
			chk("prescaled count", 8'h01, {7'h00, 8'(q + 8'h02 - 8'(num[i])) <= 8'h04});
		end
		for (int e = 0; e < 2; e++) begin
			wr(`T8_OFS_COUNT, 8'h00);
			ctl({5'h00, 3'(6 + e)});
			repeat (5) begin
				ext_count_pin_in <= 1'b1;
				repeat (4) @(posedge core_clk_in);
				ext_count_pin_in <= 1'b0;
				repeat (4) @(posedge core_clk_in);
			end
			ctl(8'h00);
			rdc(`T8_OFS_COUNT, 8'h05, "pin count");
		end
		$display("test clock select done");
		wr(`T8_OFS_COMPARE_A, 8'h40);
		wr(`T8_OFS_COMPARE_B, 8'hC8);
		for (int m = 0; m < 7; m++) begin
			ctl({4'h0, md[m][2], 3'h0});
			wr(`T8_OFS_OUT_CTRL, {6'h00, md[m][1:0]});
			wr(`T8_OFS_COUNT, st[m]);
			wr(`T8_OFS_IRQ_FLAGS, 8'h07);
			ctl({4'h0, md[m][2], 3'h1});
			repeat (win[m]) @(posedge core_clk_in);
			ctl({4'h0, md[m][2], 3'h0});
			rdc(`T8_OFS_IRQ_FLAGS, fl[m], "mode flags");
		end
		$display("test modes done");
		wr(`T8_OFS_COMPARE_A, 8'hF8);
		wr(`T8_OFS_COMPARE_B, 8'hF5);
		wr(`T8_OFS_COUNT, 8'hF0);
		ctl(8'h01);
		repeat (30) @(posedge core_clk_in);
		ctl(8'h00);
		rdc(`T8_OFS_IRQ_FLAGS, 8'h07, "all flags");
		global_irq_en_in <= 1'b1;
		for (int i = 0; i < 3; i++) begin
			wr(`T8_OFS_IRQ_MASK, 8'(8'h01 << i));
			repeat (2) @(posedge core_clk_in);
			chk("irq", 8'(8'h01 << i), {5'h00, irq_b, irq_ovf, irq_a});
		end
		global_irq_en_in <= 1'b0;
		repeat (3) @(posedge core_clk_in);
		chk("irq global off", 8'h00, {5'h00, irq_b, irq_ovf, irq_a});
		global_irq_en_in <= 1'b1;
		wr(`T8_OFS_VECTOR_ACK, 8'h04);
		repeat (2) @(posedge core_clk_in);
		chk("irq after ack", 8'h00, {5'h00, irq_b, irq_ovf, irq_a});
		wr(`T8_OFS_IRQ_FLAGS, 8'h03);
		rdc(`T8_OFS_IRQ_FLAGS, 8'h00, "flags cleared");
		$display("test interrupts done");
		for (int k = 0; k < 4; k++) begin
			wr(`T8_OFS_OUT_CTRL, {om[k], om[k], 4'h0});
			ctl(8'hC0);
			repeat (2) @(posedge core_clk_in);
			chk("forced wave", {4'h0, 2'h3, wv[k], wv[k]}, {4'h0, en_b, en_a, wave_b, wave_a});
		end
		wr(`T8_OFS_OUT_CTRL, 8'h42);
		wr(`T8_OFS_COUNT, 8'h10);
		ctl(8'h80);
		rdc(`T8_OFS_COUNT, 8'h10, "count after force");
		rdc(`T8_OFS_IRQ_FLAGS, 8'h00, "flags after force");
		wr(`T8_OFS_OUT_CTRL, 8'h43);
		ctl(8'h80);
		repeat (2) @(posedge core_clk_in);
		chk("force in pwm", 8'h01, {7'h00, wave_a});
		$display("test force done");
		test_done();
	end
endmodule : tb_top

`default_nettype wire
